// ---- hdl/adcs_defines.svh ----
// offsets, field positions, reset values and timing counts of the converter setup block
// assumes a 32-bit apb register bus and the 40 mhz pclk
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADCS_ADDR_W        8
`define ADCS_OFF_SETUP     8'h00
`define ADCS_OFF_COMM      8'h04
`define ADCS_OFF_DATA      8'h08
`define ADCS_OFF_ZS_COEF   8'h0C
`define ADCS_OFF_FS_COEF   8'h10
`define ADCS_OFF_INT_STAT  8'h14
`define ADCS_OFF_INT_MASK  8'h18

// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define ADCS_SETUP_RESET   8'h01
`define ADCS_MODE_MSB      7
`define ADCS_MODE_LSB      6
`define ADCS_GAIN_MSB      5
`define ADCS_GAIN_LSB      3
`define ADCS_POL_BIT       2
`define ADCS_BUF_BIT       1
`define ADCS_FILTER_SYNC_HOLD_BIT     0

// ----------------------------------------------------------------
// communications, interrupt fields
// ----------------------------------------------------------------
`define ADCS_COMM_DATA_READY_N_BIT 7
`define ADCS_CHAN_HI_BIT   1
`define ADCS_CHAN_LO_BIT   0
`define ADCS_INT_WORD_BIT  0
`define ADCS_INT_CAL_BIT   1
`define ADCS_INT_W         2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCS_CLK_MHZ          40
`define ADCS_UPDATE_PERIOD_US 20000
`define ADCS_UPDATE_CYCLES    (`ADCS_UPDATE_PERIOD_US * `ADCS_CLK_MHZ)
`define ADCS_SETTLE_PERIODS   3

`endif

// ---- hdl/adcs_pkg.sv ----
// types shared by the converter setup block
// assumes adcs_defines.svh for all numeric constants
package adcs_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_RUN,
    ST_SELF_ZS,
    ST_SELF_FS,
    ST_SYS_ZS,
    ST_SYS_FS
  } adcs_state_type;

  // operating mode field
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SELF_CAL,
    MODE_ZS_SYS_CAL,
    MODE_FS_SYS_CAL
  } adcs_mode_type;

endpackage : adcs_pkg

// ---- hdl/adcs_coef_mem.sv ----
// calibration coefficient store: one zero-scale and one full-scale word per pair
// assumes a single writer; read data are registered one cycle after the address
`timescale 1ns/1ps
module adcs_coef_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 3
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // write side
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic                     wr_zs_en,
  input  wire logic                     wr_fs_en,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_zs,
  output logic      [WIDTH-1:0]         rd_fs
);

  logic [WIDTH-1:0] zs_mem [DEPTH];
  logic [WIDTH-1:0] fs_mem [DEPTH];

  // array itself has no reset: contents are undefined until calibrated
  always_ff @(posedge pclk) begin
    if (wr_zs_en) begin
      zs_mem[wr_addr] <= wr_data;
    end
    if (wr_fs_en) begin
      fs_mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_zs <= '0;
      rd_fs <= '0;
    end else begin
      rd_zs <= zs_mem[rd_addr];
      rd_fs <= fs_mem[rd_addr];
    end
  end

endmodule : adcs_coef_mem

// ---- hdl/adcs_setup_ctrl.sv ----
// converter setup, mode sequencing and calibration control behind an apb slave
// assumes filt_data is the settled filter output, sampled once per update period
// Summary of operation
// - mode field selects normal or three calibrations
// - normal mode converts continuously on selected channel
// - self-cal does zero then full step
// - calibration end clears mode field to normal
// - calibration raises data-ready, word lowers it
// - zero-scale system cal samples applied input
// - full-scale system cal samples applied input
// - gain is two to the gain code
// - polarity bit zero bipolar, one unipolar
// - buffer bit zero bypasses, one inserts buffer
// - filter sync holds filter, cal, modulator reset
// - first word three update periods after release
// - filter sync never raises data-ready
// - channel code picks input and coefficient pair
// - comm read top bit mirrors data-ready pin
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_setup_ctrl #(
  parameter int UPDATE_CYCLES = `ADCS_UPDATE_CYCLES,
  parameter int COEF_W        = 24,
  parameter int PAIRS         = 3
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`ADCS_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // filter output
  input  wire logic [COEF_W-1:0]        filt_data,
  // analog front end control
  output logic      [7:0]               front_end_amp,
  output logic                          bipolar_en,
  output logic                          buf_en,
  output logic      [1:0]               in_sel,
  output logic                          in_short,
  output logic                          cal_ref_en,
  output logic                          mod_reset,
  output logic      [$clog2(PAIRS)-1:0] coef_pair,
  // status
  output logic                          data_ready_n,
  output logic                          irq
);

  localparam int TW = $clog2(UPDATE_CYCLES + 1);
  localparam int PW = $clog2(PAIRS);
  localparam logic [1:0] SETTLE_LAST = 2'(`ADCS_SETTLE_PERIODS - 1);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] pair_of(input logic [1:0] ch);
    case (ch)
      2'h1:    pair_of = PW'(1);
      2'h3:    pair_of = PW'(2);
      default: pair_of = PW'(0);
    endcase
  endfunction : pair_of

  function automatic adcs_pkg::adcs_state_type step_of(input logic [1:0] md);
    case (md)
      adcs_pkg::MODE_SELF_CAL:   step_of = adcs_pkg::ST_SELF_ZS;
      adcs_pkg::MODE_ZS_SYS_CAL: step_of = adcs_pkg::ST_SYS_ZS;
      adcs_pkg::MODE_FS_SYS_CAL: step_of = adcs_pkg::ST_SYS_FS;
      default:                   step_of = adcs_pkg::ST_SETTLE;
    endcase
  endfunction : step_of

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic                   setup_ph;
  logic                   acc_done;
  logic                   wr_en;
  logic                   rd_en;
  logic                   wr_setup;
  logic [1:0]             op_mode_sel;
  logic [2:0]             gain_code;
  logic                   unipolar;
  logic                   buf_ctl;
  logic                   filter_sync_hold;
  logic                   chan_sel_hi;
  logic                   chan_sel_lo;
  logic [15:0]            data_word;
  logic [`ADCS_INT_W-1:0] int_stat;
  logic [`ADCS_INT_W-1:0] int_mask;
  logic [COEF_W-1:0]      zs_rd;
  logic [COEF_W-1:0]      fs_rd;
  logic [31:0]            next_prdata;
  logic                   next_slverr;

  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready;
  assign wr_en    = acc_done & pwrite;
  assign rd_en    = acc_done & ~pwrite;
  assign wr_setup = wr_en && (paddr == `ADCS_OFF_SETUP);

  // one wait-free access: answer is staged in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & next_slverr;
      if (setup_ph) begin
        prdata <= next_prdata;
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `ADCS_OFF_SETUP: begin
        next_prdata[7:0] = {op_mode_sel, gain_code, unipolar, buf_ctl, filter_sync_hold};
      end
      `ADCS_OFF_COMM: begin
        next_prdata[`ADCS_COMM_DATA_READY_N_BIT] = data_ready_n;
        next_prdata[1:0] = {chan_sel_hi, chan_sel_lo};
      end
      `ADCS_OFF_DATA:     next_prdata[15:0] = data_word;
      `ADCS_OFF_ZS_COEF:  next_prdata[COEF_W-1:0] = zs_rd;
      `ADCS_OFF_FS_COEF:  next_prdata[COEF_W-1:0] = fs_rd;
      `ADCS_OFF_INT_STAT: next_prdata[`ADCS_INT_W-1:0] = int_stat;
      `ADCS_OFF_INT_MASK: next_prdata[`ADCS_INT_W-1:0] = int_mask;
      default:            next_slverr = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  adcs_pkg::adcs_state_type state;
  logic [TW-1:0]            tick_cnt;
  logic [1:0]               settle_cnt;
  logic                     tick;
  logic                     cal_start;
  logic                     cal_begin;
  logic                     in_cal;
  logic                     step_done;
  logic                     cal_done;
  logic                     word_load;
  logic                     data_read;
  logic [PW-1:0]            cal_pair;

  assign cal_start = wr_setup && (pwdata[`ADCS_MODE_MSB:`ADCS_MODE_LSB] != 2'h0);
  assign cal_begin = cal_start ||
                     (state == adcs_pkg::ST_HOLD && !filter_sync_hold && op_mode_sel != 2'h0);
  assign tick      = (tick_cnt == TW'(UPDATE_CYCLES - 1));
  assign in_cal    = (state == adcs_pkg::ST_SELF_ZS) || (state == adcs_pkg::ST_SELF_FS) ||
                     (state == adcs_pkg::ST_SYS_ZS)  || (state == adcs_pkg::ST_SYS_FS);
  assign step_done = in_cal && tick && (settle_cnt == SETTLE_LAST);
  assign cal_done  = step_done && (state != adcs_pkg::ST_SELF_ZS);
  assign word_load = tick && !filter_sync_hold &&
                     (state == adcs_pkg::ST_RUN ||
                      (state == adcs_pkg::ST_SETTLE && settle_cnt == SETTLE_LAST));
  assign data_read = rd_en && (paddr == `ADCS_OFF_DATA);

  // update-period timer restarts whenever the filter restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (filter_sync_hold || cal_start || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= adcs_pkg::ST_HOLD;
      settle_cnt <= 2'h0;
    end else if (filter_sync_hold) begin
      state      <= adcs_pkg::ST_HOLD;
      settle_cnt <= 2'h0;
    end else if (cal_start) begin
      state      <= step_of(pwdata[`ADCS_MODE_MSB:`ADCS_MODE_LSB]);
      settle_cnt <= 2'h0;
    end else begin
      case (state)
        adcs_pkg::ST_HOLD: begin
          state      <= step_of(op_mode_sel);
          settle_cnt <= 2'h0;
        end
        adcs_pkg::ST_SETTLE: begin
          if (tick) begin
            if (settle_cnt == SETTLE_LAST) begin
              state      <= adcs_pkg::ST_RUN;
              settle_cnt <= 2'h0;
            end else begin
              settle_cnt <= settle_cnt + 2'h1;
            end
          end
        end
        adcs_pkg::ST_RUN: begin
          state <= adcs_pkg::ST_RUN;
        end
        adcs_pkg::ST_SELF_ZS,
        adcs_pkg::ST_SELF_FS,
        adcs_pkg::ST_SYS_ZS,
        adcs_pkg::ST_SYS_FS: begin
          if (step_done) begin
            state <= (state == adcs_pkg::ST_SELF_ZS) ? adcs_pkg::ST_SELF_FS
                                                     : adcs_pkg::ST_SETTLE;
            settle_cnt <= 2'h0;
          end else if (tick) begin
            settle_cnt <= settle_cnt + 2'h1;
          end
        end
        default: begin
          state      <= adcs_pkg::ST_HOLD;
          settle_cnt <= 2'h0;
        end
      endcase
    end
  end

  // pair is frozen for the whole sequence so a channel change cannot split it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_pair <= '0;
    end else if (cal_begin) begin
      cal_pair <= pair_of({chan_sel_hi, chan_sel_lo});
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {op_mode_sel, gain_code, unipolar, buf_ctl, filter_sync_hold} <= `ADCS_SETUP_RESET;
    end else if (wr_setup) begin
      {op_mode_sel, gain_code, unipolar, buf_ctl, filter_sync_hold} <= pwdata[7:0];
    end else if (cal_done) begin
      op_mode_sel <= adcs_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {chan_sel_hi, chan_sel_lo} <= 2'h0;
    end else if (wr_en && paddr == `ADCS_OFF_COMM) begin
      chan_sel_hi <= pwdata[`ADCS_CHAN_HI_BIT];
      chan_sel_lo <= pwdata[`ADCS_CHAN_LO_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_word <= 16'h0000;
    end else if (word_load) begin
      data_word <= filt_data[COEF_W-1 -: 16];
    end
  end

  // cal start beats a word landing the same cycle; filter sync never sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ready_n <= 1'b1;
    end else if (cal_begin) begin
      data_ready_n <= 1'b1;
    end else if (word_load) begin
      data_ready_n <= 1'b0;
    end else if (data_read) begin
      data_ready_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`ADCS_INT_W-1:0] int_set;

  assign int_set = {cal_done, word_load};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      int_mask <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr_en && paddr == `ADCS_OFF_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[`ADCS_INT_W-1:0]) | int_set;
      end else begin
        int_stat <= int_stat | int_set;
      end
      if (wr_en && paddr == `ADCS_OFF_INT_MASK) begin
        int_mask <= pwdata[`ADCS_INT_W-1:0];
      end
      irq <= |(int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // front end control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_end_amp <= 8'h01;
      bipolar_en    <= 1'b1;
      buf_en        <= 1'b0;
      in_sel        <= 2'h0;
      in_short      <= 1'b0;
      cal_ref_en    <= 1'b0;
      mod_reset     <= 1'b1;
      coef_pair     <= '0;
    end else begin
      front_end_amp <= 8'h01 << gain_code;
      bipolar_en    <= ~unipolar;
      buf_en        <= buf_ctl;
      in_sel        <= {chan_sel_hi, chan_sel_lo};
      in_short      <= (state == adcs_pkg::ST_SELF_ZS);
      cal_ref_en    <= (state == adcs_pkg::ST_SELF_FS);
      mod_reset     <= filter_sync_hold;
      coef_pair     <= in_cal ? cal_pair : pair_of({chan_sel_hi, chan_sel_lo});
    end
  end

  // ----------------------------------------------------------------
  // coefficient store
  // ----------------------------------------------------------------
  logic wr_zs_en;
  logic wr_fs_en;

  // system steps take whatever the input holds; the host must keep it steady
  assign wr_zs_en = step_done &&
                    (state == adcs_pkg::ST_SELF_ZS || state == adcs_pkg::ST_SYS_ZS);
  assign wr_fs_en = step_done &&
                    (state == adcs_pkg::ST_SELF_FS || state == adcs_pkg::ST_SYS_FS);

  adcs_coef_mem #(
    .WIDTH (COEF_W),
    .DEPTH (PAIRS)
  ) u_coef_mem (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_addr  (cal_pair),
    .wr_zs_en (wr_zs_en),
    .wr_fs_en (wr_fs_en),
    .wr_data  (filt_data),
    .rd_addr  (pair_of({chan_sel_hi, chan_sel_lo})),
    .rd_zs    (zs_rd),
    .rd_fs    (fs_rd)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cal_data_ready_n;
    @(posedge pclk) disable iff (!presetn) cal_begin |=> data_ready_n;
  endproperty
  a_cal_data_ready_n: assert property (p_cal_data_ready_n) else $error("data ready not cleared at cal start");

  property p_data_ready_n_fall;
    @(posedge pclk) disable iff (!presetn) $fell(data_ready_n) |-> $past(word_load);
  endproperty
  a_data_ready_n_fall: assert property (p_data_ready_n_fall) else $error("data ready fell without a word");

  property p_no_sync_raise;
    @(posedge pclk) disable iff (!presetn)
      $rose(data_ready_n) |-> ($past(cal_begin) || $past(data_read));
  endproperty
  a_no_sync_raise: assert property (p_no_sync_raise) else $error("data ready raised by sync");

  property p_mode_clear;
    @(posedge pclk) disable iff (!presetn)
      (cal_done && !wr_setup && !filter_sync_hold)
        |=> (op_mode_sel == 2'h0) && (state == adcs_pkg::ST_SETTLE);
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode not back to normal");

  property p_sync_hold;
    @(posedge pclk) disable iff (!presetn)
      filter_sync_hold |=> (state == adcs_pkg::ST_HOLD) && !word_load && mod_reset;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync did not hold filter");

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
      ##1 (front_end_amp == (8'h01 << $past(gain_code)));
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (cal_start && !filter_sync_hold) |=> in_cal && (settle_cnt == 2'h0);
  endproperty
  a_start: assert property (p_start) else $error("calibration did not start");

  property p_comm_bit;
    @(posedge pclk) disable iff (!presetn)
      (setup_ph && paddr == `ADCS_OFF_COMM) |=> prdata[`ADCS_COMM_DATA_READY_N_BIT] == $past(data_ready_n);
  endproperty
  a_comm_bit: assert property (p_comm_bit) else $error("comm top bit differs from pin");

  property p_self_order;
    @(posedge pclk) disable iff (!presetn)
      (step_done && state == adcs_pkg::ST_SELF_ZS && !cal_start && !filter_sync_hold)
        |=> state == adcs_pkg::ST_SELF_FS ##1 cal_ref_en;
  endproperty
  a_self_order: assert property (p_self_order) else $error("self cal skipped full step");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn) ##1 (bipolar_en == !$past(unipolar));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity decode wrong");

endmodule : adcs_setup_ctrl

// ---- dv/adcs_filter_model.sv ----
// stand-in for modulator and filter: presents the level applied at the input
// assumes data_ready_n and mod_reset come from the setup block
`timescale 1ns/1ps
module adcs_filter_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // block status
  input  wire logic        data_ready_n,
  input  wire logic        mod_reset,
  // applied input level
  input  wire logic [23:0] level,
  // filter output
  output logic      [23:0] filt_data
);
  // ----------------------------------------------------------------
  // input tracking
  // ----------------------------------------------------------------
  // frozen while a sequence runs, so a calibration never sees a moving input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_data <= 24'h000000;
    end else if (mod_reset || !data_ready_n) begin
      filt_data <= level;
    end
  end
endmodule : adcs_filter_model

// ---- dv/adc_setup_mode_and_calibration_tb.sv ----
// self-checking bench for the converter setup block
// assumes a shortened update period of UPD cycles and a 40 mhz pclk
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adc_setup_mode_and_calibration_tb;
  localparam int UPD = 20;
  typedef struct packed {
    logic [7:0] setup;
    logic [1:0] chan;
    logic [7:0] amp;
    logic [1:0] pair;
  } adcs_row_type;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]   paddr, front_end_amp;
  logic [31:0]  pwdata, prdata, q;
  logic [23:0]  filt_data, level;
  logic [1:0]   in_sel, coef_pair;
  logic         bipolar_en, buf_en, in_short, cal_ref_en, mod_reset, data_ready_n, irq;
  int           err_total, checks_done, n;
  adcs_row_type rows [8];

  adcs_setup_ctrl #(.UPDATE_CYCLES(UPD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_data(filt_data), .front_end_amp(front_end_amp), .bipolar_en(bipolar_en),
    .buf_en(buf_en), .in_sel(in_sel), .in_short(in_short), .cal_ref_en(cal_ref_en),
    .mod_reset(mod_reset), .coef_pair(coef_pair), .data_ready_n(data_ready_n), .irq(irq));
  adcs_filter_model model (
    .pclk(pclk), .presetn(presetn), .data_ready_n(data_ready_n), .mod_reset(mod_reset),
    .level(level), .filt_data(filt_data));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic give_up(input string msg);
    check(1'b0, msg);
    complete_run();
  endtask : give_up

  // one idle cycle after each transfer keeps every drive to one per time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) give_up("no pready");
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_ready(input int lim);
    n = 0;
    while (data_ready_n !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > lim) give_up("ready never came");
    end
  endtask : wait_ready

  task automatic run_cal(input logic [7:0] su, input logic [1:0] ch, input logic [23:0] lv);
    int fs, fr, len;
    logic is_self;
    is_self = (su[7:6] == 2'b01);
    len = is_self ? 9 * UPD : 6 * UPD;
    apb(1'b1, `ADCS_OFF_COMM, {30'h0, ch});
    wait_ready(UPD + 4);
    level <= lv;
    repeat (3) @(posedge pclk);
    apb(1'b1, `ADCS_OFF_SETUP, {24'h0, su});
    @(posedge pclk);
    check(data_ready_n === 1'b1, "ready low at cal start");
    fs = 0;
    fr = 0;
    n = 0;
    while (data_ready_n !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > 12 * UPD) give_up("cal never ended");
      if (in_short === 1'b1 && fs == 0) fs = n;
      if (cal_ref_en === 1'b1 && fr == 0) fr = n;
      if (in_sel !== ch || front_end_amp !== (8'h01 << su[5:3])) check(1'b0, "setup in cal");
    end
    check(n >= len - 4 && n <= len + 3, "cal length");
    check(is_self ? (fs > 0 && fr > fs) : (fs == 0 && fr == 0), "cal steps");
    apb(1'b0, `ADCS_OFF_SETUP, 32'h0);
    check(q === {24'h0, su & 8'h3F}, "mode not cleared");
    check(irq === 1'b1, "no cal irq");
    apb(1'b1, `ADCS_OFF_INT_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    check(irq === 1'b0, "irq not cleared");
    apb(1'b0, `ADCS_OFF_DATA, 32'h0);
    check(q[15:0] === lv[23:8], "word after cal");
    $display("test cal %0h done", su);
  endtask : run_cal

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 24'hA5C3F0;
    err_total = 0;
    checks_done = 0;
    rows[0] = '{8'h01, 2'd0, 8'h01, 2'd0};
    rows[1] = '{8'h0D, 2'd1, 8'h02, 2'd1};
    rows[2] = '{8'h13, 2'd2, 8'h04, 2'd0};
    rows[3] = '{8'h1F, 2'd3, 8'h08, 2'd2};
    rows[4] = '{8'h21, 2'd0, 8'h10, 2'd0};
    rows[5] = '{8'h2D, 2'd1, 8'h20, 2'd1};
    rows[6] = '{8'h33, 2'd2, 8'h40, 2'd0};
    rows[7] = '{8'h3F, 2'd3, 8'h80, 2'd2};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(front_end_amp === 8'h01 && bipolar_en === 1'b1 && mod_reset === 1'b1, "reset");
    check(data_ready_n === 1'b1 && irq === 1'b0, "reset status");
    apb(1'b0, `ADCS_OFF_SETUP, 32'h0);
    check(q === 32'h01, "setup reset value");
    apb(1'b0, `ADCS_OFF_COMM, 32'h0);
    check(q[7] === 1'b1, "comm ready bit high");
    apb(1'b0, 8'h1C, 32'h0);
    check(perr === 1'b1 && q === 32'h0, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `ADCS_OFF_SETUP, {24'h0, rows[i].setup});
      apb(1'b1, `ADCS_OFF_COMM, {30'h0, rows[i].chan});
      repeat (3) @(posedge pclk);
      check(front_end_amp === rows[i].amp, "gain");
      check(bipolar_en === ~rows[i].setup[2] && buf_en === rows[i].setup[1], "pol buf");
      check(in_sel === rows[i].chan && coef_pair === rows[i].pair, "channel");
      check(mod_reset === 1'b1 && data_ready_n === 1'b1, "sync hold");
    end
    $display("test table done");
    apb(1'b1, `ADCS_OFF_INT_MASK, 32'h2);
    apb(1'b1, `ADCS_OFF_SETUP, 32'h0);
    wait_ready(3 * UPD + 8);
    check(n >= 3 * UPD - 4 && mod_reset === 1'b0, "settle time");
    apb(1'b0, `ADCS_OFF_DATA, 32'h0);
    check(q[15:0] === level[23:8], "first word");
    wait_ready(UPD + 4);
    $display("test settle done");
    run_cal(8'h50, 2'b01, 24'h3C5A96);
    run_cal(8'hD8, 2'b11, 24'hE1F00F);
    run_cal(8'h98, 2'b11, 24'h0781E4);
    apb(1'b0, `ADCS_OFF_ZS_COEF, 32'h0);
    check(q[23:0] === 24'h0781E4, "pair 2 zero scale");
    apb(1'b0, `ADCS_OFF_FS_COEF, 32'h0);
    check(q[23:0] === 24'hE1F00F, "pair 2 full scale");
    apb(1'b1, `ADCS_OFF_COMM, 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b0, `ADCS_OFF_ZS_COEF, 32'h0);
    check(q[23:0] === 24'h3C5A96, "pair 1 zero scale");
    apb(1'b0, `ADCS_OFF_FS_COEF, 32'h0);
    check(q[23:0] === 24'h3C5A96, "pair 1 full scale");
    $display("test coefficients done");
    wait_ready(UPD + 4);
    apb(1'b1, `ADCS_OFF_SETUP, 32'h01);
    repeat (3 * UPD) @(posedge pclk);
    check(data_ready_n === 1'b0 && mod_reset === 1'b1, "sync dropped ready");
    apb(1'b0, `ADCS_OFF_COMM, 32'h0);
    check(q[7] === 1'b0, "comm ready bit low");
    $display("test sync done");
    complete_run();
  end
endmodule : adc_setup_mode_and_calibration_tb
